// file: src/t2x_pkg.sv
package t2x_pkg;
   // line format selection
   typedef enum logic [1:0] {
      T2X_MODE_T3   = 2'h0,
      T2X_MODE_E3   = 2'h1,
      T2X_MODE_G747 = 2'h3
   } t2x_mode_t;

   // per channel bit slot marks and data from the second-order frame timing
   typedef struct packed {
      logic frame_start; // first bit of a frame
      logic fas_slot;    // bit is a framing/alignment bit
      logic rai_slot;    // X bit (T3) or remote-alarm bit (E3/G.747)
      logic nat_slot;    // E2 national bit
      logic data;        // the bit itself
   } t2x_slot_t;

   // bus geometry
   localparam int          T2X_ADDR_W = 10;
   localparam int          T2X_DATA_W = 32;
   localparam int          T2X_TRIB_W = 28;
   localparam int          T2X_MAX_CH = 7;
   localparam int          T2X_NAT_CH = 4;

   // printed register indices, byte address is four times the index
   localparam logic [7:0]  T2X_IDX_ALARM_CTRL = 8'h30;
   localparam logic [7:0]  T2X_IDX_LOF_NAT    = 8'h32;
   localparam logic [T2X_ADDR_W-1:0] T2X_ADR_ALARM_CTRL = {T2X_IDX_ALARM_CTRL, 2'h0};
   localparam logic [T2X_ADDR_W-1:0] T2X_ADR_LOF_NAT    = {T2X_IDX_LOF_NAT, 2'h0};
   localparam logic [T2X_ADDR_W-1:0] T2X_ADR_MODE       = 10'h000;
   localparam logic [T2X_ADDR_W-1:0] T2X_ADR_STATUS     = 10'h004;
   localparam logic [T2X_ADDR_W-1:0] T2X_ADR_TRIB_TX    = 10'h008;
   localparam logic [T2X_ADDR_W-1:0] T2X_ADR_TRIB_RX    = 10'h00C;

   // field positions
   localparam int          T2X_LO_FIELD  = 0;  // remote alarm / burst trigger
   localparam int          T2X_HI_FIELD  = 8;  // all-ones alarm / national bits
   localparam int          T2X_MODE_LSB  = 0;
   localparam int          T2X_RESYNC_B  = 2;

   // reset values
   localparam logic [T2X_TRIB_W-1:0] T2X_TRIB_RST = 28'hFFFFFFF;
   localparam logic [6:0]  T2X_CH_RST    = 7'h00;
   localparam logic [3:0]  T2X_NAT_RST   = 4'h0;

   // frame counts
   localparam logic [2:0]  T2X_BURST_FRAMES = 3'h4;
   localparam logic [2:0]  T2X_RAI_FRAMES   = 3'h4;
endpackage

// file: src/t2x_framer_ctl.sv
// Local design decision: register access over APB.
`timescale 1ns/1ns
// Behaviour
// [RULE_01] T3: X bit zero while remote alarm control high, one while low.
// [RULE_02] E3: remote alarm control high sets E2 frame bit 11 to one.
// [RULE_03] G.747: remote alarm control high sets set 2 bit 1 to one.
// [RULE_04] E3 and G.747: control low sends the remote alarm bit as zero.
// [RULE_05] E3: host keeps channel five to seven alarm controls low.
// [RULE_06] All-ones control high sends unframed ones, low sends normal data.
// [RULE_07] Rising edge of burst trigger inserts framing errors to break far sync.
// [RULE_08] Held trigger gives one burst; host clears and sets again for more.
// [RULE_09] T3: burst is four consecutive errored F bits; code inverts every F bit over four frames, as in E3 and G.747.
// [RULE_10] E3: burst is four alignment words with every bit inverted.
// [RULE_11] G.747: burst is four alignment words with every bit inverted.
// [RULE_12] E3: national bits forced to control bits 8 to 11, else ignored.
// [RULE_13] After reset all tributary streams carry forced AIS both directions.
// [RULE_14] Host programs tributary AIS registers before passing normal traffic.
// [RULE_15] Setting the resync control makes receive framers resynchronize.
// [RULE_16] Receive framers find frame boundaries and watch for alarms.
// [RULE_17] Formatters build framing and overhead and allow alarm injection.
// [RULE_18] Host ignores these controls when multiplexing is disabled.
// [RULE_19] Received national bit is captured in every E2 frame.
// [RULE_20] T2: remote alarm set after four X zero frames, cleared after four ones.
// [RULE_21] Channel n sits at bit n minus one within its byte.
// [RULE_22] Burst starts at the next frame boundary after the trigger edge.
module t2x_framer_ctl
   import t2x_pkg::*;
#(
   parameter int NCH = 7
) (
   // clock, reset, enable
   input  wire logic                   SYS_CLK_I,
   input  wire logic                   RST_N_I,
   input  wire logic                   CE_I,
   // apb slave
   input  wire logic                   PSEL_I,
   input  wire logic                   PENABLE_I,
   input  wire logic                   PWRITE_I,
   input  wire logic [T2X_ADDR_W-1:0]  PADDR_I,
   input  wire logic [T2X_DATA_W-1:0]  PWDATA_I,
   input  wire logic [3:0]             PSTRB_I,
   output logic      [T2X_DATA_W-1:0]  PRDATA_O,
   output logic                        PREADY_O,
   output logic                        PSLVERR_O,
   // transmit formatter stream
   input  wire t2x_slot_t [NCH-1:0]    TX_SLOT_I,
   output logic           [NCH-1:0]    TX_BIT_O,
   // receive framer stream
   input  wire t2x_slot_t [NCH-1:0]    RX_SLOT_I,
   output logic           [NCH-1:0]    RX_REMOTE_ALARM_O,
   output logic                        RX_RESYNC_O,
   // tributary alarm forcing
   output logic [T2X_TRIB_W-1:0]       TRIB_TX_AIS_O,
   output logic [T2X_TRIB_W-1:0]       TRIB_RX_AIS_O
);

   // channel count check, refused at elaboration
   if (NCH < 1 || NCH > T2X_MAX_CH) begin : g_bad_nch
      $error("NCH must lie between 1 and 7");
   end

   // only the first four channels carry an E2 national bit
   localparam int NNAT = (NCH < T2X_NAT_CH) ? NCH : T2X_NAT_CH;

   // channels left working per mode, E3 drops the upper three
   localparam logic [6:0] ALL_CH_MASK = 7'h7F;
   localparam logic [6:0] E3_CH_MASK  = 7'h0F;

   // registers
   logic [6:0]            tx_remote_alarm_ch_ff;
   logic [6:0]            tx_all_ones_alarm_ch_ff;
   logic [6:0]            frame_loss_burst_trigger_ch_ff;
   logic [3:0]            e2_national_bit_value_ff;
   t2x_mode_t             mode_ff;
   logic                  resync_ff;
   logic [T2X_TRIB_W-1:0] trib_tx_alarm_force_a_ff;
   logic [T2X_TRIB_W-1:0] trib_rx_alarm_force_a_ff;
   logic [T2X_DATA_W-1:0] prdata_ff;
   logic [NCH-1:0]        tx_bit_ff;
   logic [NCH-1:0]        rx_rai_ff;
   logic [3:0]            rx_nat_ff;

   logic                  wr_en;
   logic                  rd_setup;
   logic                  hit;
   logic [T2X_DATA_W-1:0] nxt_prdata;
   logic [T2X_DATA_W-1:0] status_word;
   logic [6:0]            ch_mask;
   logic                  sel_alarm;
   logic                  sel_lof_nat;
   logic                  sel_mode;
   logic                  sel_status;
   logic                  sel_trib_tx;
   logic                  sel_trib_rx;

   // one select per mapped word, a miss is answered with an error
   assign sel_alarm   = (PADDR_I == T2X_ADR_ALARM_CTRL);
   assign sel_lof_nat = (PADDR_I == T2X_ADR_LOF_NAT);
   assign sel_mode    = (PADDR_I == T2X_ADR_MODE);
   assign sel_status  = (PADDR_I == T2X_ADR_STATUS);
   assign sel_trib_tx = (PADDR_I == T2X_ADR_TRIB_TX);
   assign sel_trib_rx = (PADDR_I == T2X_ADR_TRIB_RX);
   assign hit         = sel_alarm | sel_lof_nat | sel_mode |
                        sel_status | sel_trib_tx | sel_trib_rx;

   // apb decode, zero wait states while enabled
   // an errored write is dropped so no unmapped word aliases a register
   assign wr_en    = CE_I & PSEL_I & PENABLE_I & PWRITE_I & ~PSLVERR_O;
   assign rd_setup = CE_I & PSEL_I & ~PENABLE_I & ~PWRITE_I;
   assign PREADY_O = CE_I;
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;

   // channels five to seven disabled in E3
   assign ch_mask = (mode_ff == T2X_MODE_E3) ? E3_CH_MASK : ALL_CH_MASK; // RULE_05

   // control register writes, low byte lane holds per channel bits
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         tx_remote_alarm_ch_ff          <= T2X_CH_RST;
         tx_all_ones_alarm_ch_ff        <= T2X_CH_RST;
         frame_loss_burst_trigger_ch_ff <= T2X_CH_RST;
         e2_national_bit_value_ff       <= T2X_NAT_RST;
      end else if (wr_en) begin
         // a lane that is not strobed keeps its field
         if (sel_alarm) begin
            if (PSTRB_I[0]) begin
               tx_remote_alarm_ch_ff <= PWDATA_I[T2X_LO_FIELD +: 7]; // RULE_21
            end
            if (PSTRB_I[1]) begin
               tx_all_ones_alarm_ch_ff <= PWDATA_I[T2X_HI_FIELD +: 7];
            end
         end
         if (sel_lof_nat) begin
            if (PSTRB_I[0]) begin
               frame_loss_burst_trigger_ch_ff <= PWDATA_I[T2X_LO_FIELD +: 7];
            end
            if (PSTRB_I[1]) begin
               e2_national_bit_value_ff <= PWDATA_I[T2X_HI_FIELD +: 4];
            end
         end
      end
   end

   // mode register and one-cycle resync request
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mode_ff   <= T2X_MODE_T3;
         resync_ff <= 1'b0;
      end else if (CE_I) begin
         resync_ff <= 1'b0;
         if (wr_en && sel_mode && PSTRB_I[0]) begin
            mode_ff   <= t2x_mode_t'(PWDATA_I[T2X_MODE_LSB +: 2]);
            resync_ff <= PWDATA_I[T2X_RESYNC_B]; // RULE_15
         end
      end
   end

   // tributary AIS forcing, all forced from reset
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         trib_tx_alarm_force_a_ff <= T2X_TRIB_RST; // RULE_13
         trib_rx_alarm_force_a_ff <= T2X_TRIB_RST; // RULE_13
      end else if (wr_en) begin
         // a zero bit lets that tributary pass normal traffic
         if (sel_trib_tx) begin
            trib_tx_alarm_force_a_ff <= PWDATA_I[T2X_TRIB_W-1:0]; // RULE_14
         end
         if (sel_trib_rx) begin
            trib_rx_alarm_force_a_ff <= PWDATA_I[T2X_TRIB_W-1:0]; // RULE_14
         end
      end
   end

   // read mux
   always_comb begin
      status_word = '0;
      status_word[T2X_LO_FIELD +: NCH] = rx_rai_ff;
      status_word[T2X_HI_FIELD +: 4]   = rx_nat_ff;
      nxt_prdata = '0;
      case (PADDR_I)
         T2X_ADR_ALARM_CTRL: begin
            nxt_prdata[T2X_LO_FIELD +: 7] = tx_remote_alarm_ch_ff;
            nxt_prdata[T2X_HI_FIELD +: 7] = tx_all_ones_alarm_ch_ff;
         end
         T2X_ADR_LOF_NAT: begin
            nxt_prdata[T2X_LO_FIELD +: 7] = frame_loss_burst_trigger_ch_ff;
            nxt_prdata[T2X_HI_FIELD +: 4] = e2_national_bit_value_ff;
         end
         T2X_ADR_MODE: begin
            nxt_prdata[T2X_MODE_LSB +: 2] = mode_ff;
         end
         T2X_ADR_STATUS: begin
            nxt_prdata = status_word;
         end
         T2X_ADR_TRIB_TX: begin
            nxt_prdata[T2X_TRIB_W-1:0] = trib_tx_alarm_force_a_ff;
         end
         T2X_ADR_TRIB_RX: begin
            nxt_prdata[T2X_TRIB_W-1:0] = trib_rx_alarm_force_a_ff;
         end
         default:         nxt_prdata = '0;
      endcase
   end

   // read data captured in the setup cycle
   // so it stands unchanged through the whole access phase
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         prdata_ff <= '0;
      end else if (rd_setup) begin
         prdata_ff <= nxt_prdata;
      end
   end

   // per channel formatter and receive monitor
   for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      // per channel burst, override and alarm state
      logic       trig_d_ff;
      logic       arm_ff;
      logic [2:0] burst_cnt_ff;
      logic [2:0] nxt_burst_cnt;
      logic       burst_on;
      logic       rai_on;
      logic       ais_on;
      logic       nxt_tx_bit;
      logic [2:0] rai_cnt_ff;
      logic       want_rai;
      t2x_slot_t  ts;
      t2x_slot_t  rs;

      // this channel's slot marks and masked controls
      assign ts     = TX_SLOT_I[ch];
      assign rs     = RX_SLOT_I[ch];
      assign rai_on = tx_remote_alarm_ch_ff[ch] & ch_mask[ch];
      assign ais_on = tx_all_ones_alarm_ch_ff[ch] & ch_mask[ch];

      // remaining errored frames, reloaded at the frame after the edge
      always_comb begin
         nxt_burst_cnt = burst_cnt_ff;
         if (ts.frame_start) begin
            if (arm_ff) begin
               nxt_burst_cnt = T2X_BURST_FRAMES; // RULE_22
            end else if (burst_cnt_ff != 3'h0) begin
               nxt_burst_cnt = burst_cnt_ff - 3'h1;
            end
         end
         burst_on = (nxt_burst_cnt != 3'h0);
      end

      // trigger edge detection and burst counting
      always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
         if (!RST_N_I) begin
            trig_d_ff    <= 1'b0;
            arm_ff       <= 1'b0;
            burst_cnt_ff <= 3'h0;
         end else if (CE_I) begin
            trig_d_ff    <= frame_loss_burst_trigger_ch_ff[ch];
            burst_cnt_ff <= nxt_burst_cnt; // RULE_09 RULE_10 RULE_11
            if (frame_loss_burst_trigger_ch_ff[ch] & ~trig_d_ff & ch_mask[ch]) begin
               arm_ff <= 1'b1; // RULE_07 RULE_08
            end else if (ts.frame_start) begin
               arm_ff <= 1'b0;
            end
         end
      end

      // overhead overrides on the outgoing bit
      always_comb begin
         nxt_tx_bit = ts.data; // RULE_17
         if (ts.fas_slot && burst_on) begin
            nxt_tx_bit = ~ts.data; // RULE_09 RULE_10 RULE_11
         end
         if (ts.rai_slot) begin
            if (mode_ff == T2X_MODE_T3) begin
               nxt_tx_bit = ~rai_on; // RULE_01
            end else begin
               nxt_tx_bit = rai_on; // RULE_02 RULE_03 RULE_04
            end
         end
         if (ts.nat_slot && mode_ff == T2X_MODE_E3 && ch < NNAT) begin
            nxt_tx_bit = e2_national_bit_value_ff[ch % T2X_NAT_CH]; // RULE_12
         end
         if (ais_on) begin
            nxt_tx_bit = 1'b1; // RULE_06
         end
      end

      // outgoing bit register, idles at one so reset sends all ones
      always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
         if (!RST_N_I) begin
            tx_bit_ff[ch] <= 1'b1;
         end else if (CE_I) begin
            tx_bit_ff[ch] <= nxt_tx_bit;
         end
      end

      // received X bit persistence, X zero means alarm
      // a matching sample restarts the count, only an unbroken run flips it
      assign want_rai = ~rs.data;
      always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
         if (!RST_N_I) begin
            rai_cnt_ff    <= 3'h0;
            rx_rai_ff[ch] <= 1'b0;
         end else if (CE_I) begin
            if (resync_ff || mode_ff != T2X_MODE_T3) begin
               rai_cnt_ff    <= 3'h0;
               rx_rai_ff[ch] <= 1'b0;
            end else if (rs.rai_slot) begin
               if (want_rai == rx_rai_ff[ch]) begin
                  rai_cnt_ff <= 3'h0;
               end else if (rai_cnt_ff == T2X_RAI_FRAMES - 3'h1) begin
                  rai_cnt_ff    <= 3'h0;
                  rx_rai_ff[ch] <= want_rai; // RULE_20 RULE_16
               end else begin
                  rai_cnt_ff <= rai_cnt_ff + 3'h1;
               end
            end
         end
      end

      // received national bit capture
      if (ch < T2X_NAT_CH) begin : g_nat
         always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
               rx_nat_ff[ch] <= 1'b0;
            end else if (CE_I && rs.nat_slot) begin
               rx_nat_ff[ch] <= rs.data; // RULE_19
            end
         end
      end
   end

   // unused national captures when fewer than four channels
   for (genvar k = NCH; k < T2X_NAT_CH; k++) begin : g_nat_pad
      assign rx_nat_ff[k] = 1'b0;
   end

   // outputs
   assign PRDATA_O          = prdata_ff;
   assign TX_BIT_O          = tx_bit_ff;
   assign RX_REMOTE_ALARM_O = rx_rai_ff;
   assign RX_RESYNC_O       = resync_ff; // RULE_15
   assign TRIB_TX_AIS_O     = trib_tx_alarm_force_a_ff;
   assign TRIB_RX_AIS_O     = trib_rx_alarm_force_a_ff;

endmodule // t2x_framer_ctl

// file: sim/t2x_far_end.sv
`timescale 1ns/1ns
module t2x_far_end
   import t2x_pkg::*;
#(
   parameter int NCH = 7,
   parameter int FL  = 12
) (
   // clock and reset
   input  wire logic           clk_i,
   input  wire logic           rst_n_i,
   // x bit sent back
   input  wire logic           x_bit_i,
   // slot streams
   output t2x_slot_t [NCH-1:0] tx_slot_o,
   output t2x_slot_t [NCH-1:0] rx_slot_o
);
   logic [7:0] pos_ff;
   t2x_slot_t  s;
   // bit counter within the frame
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pos_ff <= 8'h00;
      end else begin
         pos_ff <= (pos_ff == 8'(FL - 1)) ? 8'h00 : pos_ff + 8'h01;
      end
   end
   // alignment bits first, then alarm and national bits, data changing
   always_comb begin
      s.frame_start = (pos_ff == 8'h00);
      s.fas_slot    = (pos_ff < 8'h04);
      s.rai_slot    = (pos_ff == 8'h05);
      s.nat_slot    = (pos_ff == 8'h07);
      s.data        = pos_ff[0] ^ pos_ff[2];
      for (int i = 0; i < NCH; i++) begin
         tx_slot_o[i]      = s;
         rx_slot_o[i]      = s;
         rx_slot_o[i].data = s.rai_slot ? x_bit_i : s.data;
         if (s.nat_slot) begin
            rx_slot_o[i].data = ~x_bit_i;
         end
      end
   end
endmodule // t2x_far_end

// file: sim/t2x_framer_ctl_checker.sv
`timescale 1ns/1ns
module t2x_framer_ctl_checker
   import t2x_pkg::*;
#(
   parameter int NCH = 7
) (
   // clock, reset and enable
   input wire logic                  SYS_CLK_I,
   input wire logic                  RST_N_I,
   input wire logic                  CE_I,
   // apb
   input wire logic                  PSEL_I,
   input wire logic                  PENABLE_I,
   input wire logic                  PWRITE_I,
   input wire logic [T2X_ADDR_W-1:0] PADDR_I,
   input wire logic [T2X_DATA_W-1:0] PWDATA_I,
   input wire logic [3:0]            PSTRB_I,
   input wire logic                  PREADY_O,
   // streams
   input wire t2x_slot_t [NCH-1:0]   TX_SLOT_I,
   input wire logic [NCH-1:0]        TX_BIT_O,
   input wire logic                  RX_RESYNC_O,
   input wire logic [T2X_TRIB_W-1:0] TRIB_TX_AIS_O,
   input wire logic [T2X_TRIB_W-1:0] TRIB_RX_AIS_O
);
   logic       wr;
   logic       quiet;
   logic [1:0] mode_ff;
   logic [6:0] rai_ff;
   logic [6:0] ais_ff;
   logic [3:0] nat_ff;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // completed writes, channel one free of all-ones
   assign wr    = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I == 4'hF;
   assign quiet = CE_I && !ais_ff[0];
   // shadow of the control fields
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mode_ff <= 2'h0;
         rai_ff  <= 7'h00;
         ais_ff  <= 7'h00;
         nat_ff  <= 4'h0;
      end else if (wr && PADDR_I == T2X_ADR_MODE) begin
         mode_ff <= PWDATA_I[1:0];
      end else if (wr && PADDR_I == T2X_ADR_ALARM_CTRL) begin
         rai_ff  <= PWDATA_I[6:0];
         ais_ff  <= PWDATA_I[14:8];
      end else if (wr && PADDR_I == T2X_ADR_LOF_NAT) begin
         nat_ff  <= PWDATA_I[11:8];
      end
   end
   sequence s_rai_slot;
      quiet && TX_SLOT_I[0].rai_slot;
   endsequence
   sequence s_resync_wr;
      wr && PADDR_I == T2X_ADR_MODE && PWDATA_I[T2X_RESYNC_B];
   endsequence
   property p_trib_reset;
      $rose(RST_N_I) |-> (&TRIB_TX_AIS_O) && (&TRIB_RX_AIS_O);
   endproperty
   a_trib_reset: assert property (p_trib_reset)
      else $error("tributary alarms not forced");
   property p_x_bit;
      s_rai_slot ##0 mode_ff == T2X_MODE_T3 |=> TX_BIT_O[0] == !$past(rai_ff[0]);
   endproperty
   a_x_bit: assert property (p_x_bit)
      else $error("x bit wrong");
   property p_rai_set;
      s_rai_slot ##0 (mode_ff != T2X_MODE_T3 && rai_ff[0]) |=> TX_BIT_O[0];
   endproperty
   a_rai_set: assert property (p_rai_set)
      else $error("alarm bit not set");
   property p_rai_clr;
      s_rai_slot ##0 (mode_ff != T2X_MODE_T3 && !rai_ff[0]) |=> !TX_BIT_O[0];
   endproperty
   a_rai_clr: assert property (p_rai_clr)
      else $error("alarm bit not clear");
   property p_all_ones;
      CE_I && ais_ff[0] |=> TX_BIT_O[0];
   endproperty
   a_all_ones: assert property (p_all_ones)
      else $error("all ones missing");
   property p_data;
      quiet && !TX_SLOT_I[0].fas_slot && !TX_SLOT_I[0].rai_slot && !TX_SLOT_I[0].nat_slot
         |=> TX_BIT_O[0] == $past(TX_SLOT_I[0].data);
   endproperty
   a_data: assert property (p_data)
      else $error("data not passed");
   property p_national;
      quiet && TX_SLOT_I[0].nat_slot && mode_ff == T2X_MODE_E3
         |=> TX_BIT_O[0] == $past(nat_ff[0]);
   endproperty
   a_national: assert property (p_national)
      else $error("national bit wrong");
   property p_resync;
      s_resync_wr |=> RX_RESYNC_O ##1 !RX_RESYNC_O;
   endproperty
   a_resync: assert property (p_resync)
      else $error("resync pulse wrong");
endmodule // t2x_framer_ctl_checker

bind t2x_framer_ctl t2x_framer_ctl_checker #(.NCH(NCH)) u_t2x_framer_ctl_checker (
   .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
   .PSTRB_I(PSTRB_I), .PREADY_O(PREADY_O), .TX_SLOT_I(TX_SLOT_I), .TX_BIT_O(TX_BIT_O),
   .RX_RESYNC_O(RX_RESYNC_O), .TRIB_TX_AIS_O(TRIB_TX_AIS_O), .TRIB_RX_AIS_O(TRIB_RX_AIS_O)
);

// file: sim/tb_t2x_framer_ctl.sv
`timescale 1ns/1ns
module tb_t2x_framer_ctl import t2x_pkg::*;;
   localparam int         NCH = 7;
   localparam int         FL  = 12;
   logic                  clk, rst_n, psel, penable, pwrite, x_bit, pready, err, resync;
   logic                  prev_fas, prev_rai, prev_nat, prev_data;
   logic [T2X_ADDR_W-1:0] paddr;
   logic [T2X_DATA_W-1:0] pwdata, prdata, rd;
   logic [NCH-1:0]        tx_bit, rx_ra;
   logic [T2X_TRIB_W-1:0] trib_tx, trib_rx;
   t2x_slot_t [NCH-1:0]   tx_slot, rx_slot;
   int                    mismatches, comparisons, flips, cycles;
   t2x_framer_ctl #(.NCH(NCH)) u_t2x_framer_ctl (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(err), .TX_SLOT_I(tx_slot),
      .TX_BIT_O(tx_bit), .RX_SLOT_I(rx_slot), .RX_REMOTE_ALARM_O(rx_ra),
      .RX_RESYNC_O(resync), .TRIB_TX_AIS_O(trib_tx), .TRIB_RX_AIS_O(trib_rx));
   t2x_far_end #(.NCH(NCH), .FL(FL)) u_t2x_far_end (
      .clk_i(clk), .rst_n_i(rst_n), .x_bit_i(x_bit), .tx_slot_o(tx_slot), .rx_slot_o(rx_slot));
   // clock
   always #50 clk = ~clk;
   // alignment bits of channel one that differ from the sent data
   always @(posedge clk) begin
      if (prev_fas && tx_bit[0] !== prev_data) flips++;
      prev_fas  <= tx_slot[0].fas_slot;
      prev_rai  <= tx_slot[0].rai_slot;
      prev_nat  <= tx_slot[0].nat_slot;
      prev_data <= tx_slot[0].data;
   end
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer, read data and error taken at the completing edge
   task automatic apb(input logic w, input logic [T2X_ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd       = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // outgoing bits of all channels in the next alarm or national slot
   task automatic check_at(input logic nat, input logic [6:0] exp);
      @(posedge clk);
      do @(posedge clk); while ((nat ? prev_nat : prev_rai) !== 1'b1);
      cmp({25'h0, tx_bit}, {25'h0, exp});
   endtask
   // write the trigger field, count inverted alignment bits over six frames
   task automatic burst(input logic [31:0] trig, input logic [31:0] exp);
      apb(1'b1, T2X_ADR_LOF_NAT, trig);
      flips = 0;
      repeat (6 * FL) @(posedge clk);
      cmp(flips, exp);
   endtask
   initial begin
      {clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      x_bit       = 1'b1;
      mismatches  = 0;
      comparisons = 0;
      cycles      = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      cmp({4'h0, trib_tx & trib_rx}, {4'h0, T2X_TRIB_RST});
      apb(1'b0, 10'h3F0, 32'h0);
      cmp({rd[30:0], err}, 32'h1);
      apb(1'b1, T2X_ADR_TRIB_TX, 32'h0);
      apb(1'b1, T2X_ADR_TRIB_RX, 32'h5);
      @(posedge clk);
      cmp({4'h0, trib_tx | trib_rx}, 32'h5);
      apb(1'b0, T2X_ADR_ALARM_CTRL, 32'h0);
      cmp(rd, 32'h0);
      apb(1'b1, T2X_ADR_ALARM_CTRL, 32'hFFFFFFFF);
      apb(1'b0, T2X_ADR_ALARM_CTRL, 32'h0);
      cmp(rd, 32'h00007F7F);
      check_at(1'b0, 7'h7F);
      apb(1'b1, T2X_ADR_ALARM_CTRL, 32'h1);
      check_at(1'b0, 7'h7E);
      apb(1'b1, T2X_ADR_MODE, 32'h1);
      check_at(1'b0, 7'h01);
      apb(1'b1, T2X_ADR_MODE, 32'h3);
      check_at(1'b0, 7'h01);
      apb(1'b1, T2X_ADR_ALARM_CTRL, 32'h0);
      check_at(1'b0, 7'h00);
      apb(1'b1, T2X_ADR_MODE, 32'h1);
      apb(1'b1, T2X_ADR_LOF_NAT, 32'h500);
      check_at(1'b1, 7'h05);
      apb(1'b1, T2X_ADR_MODE, 32'h3);
      check_at(1'b1, 7'h00);
      for (int m = 0; m < 4; m++) begin
         if (m != 2) begin
            apb(1'b1, T2X_ADR_MODE, m);
            burst(32'h1, 32'(T2X_BURST_FRAMES) * 4);
            burst(32'h1, 32'h0);
            burst(32'h0, 32'h0);
         end
      end
      apb(1'b1, T2X_ADR_MODE, 32'h0);
      x_bit <= 1'b0;
      repeat (3 * FL) @(posedge clk);
      cmp({25'h0, rx_ra}, 32'h0);
      repeat (2 * FL) @(posedge clk);
      cmp({25'h0, rx_ra}, 32'h7F);
      apb(1'b0, T2X_ADR_STATUS, 32'h0);
      cmp(rd, 32'h00000F7F);
      apb(1'b1, T2X_ADR_MODE, 32'h4);
      repeat (3) @(posedge clk);
      cmp({25'h0, rx_ra}, 32'h0);
      apb(1'b0, T2X_ADR_MODE, 32'h0);
      cmp(rd, 32'h0);
      repeat (5 * FL) @(posedge clk);
      x_bit <= 1'b1;
      repeat (3 * FL) @(posedge clk);
      cmp({25'h0, rx_ra}, 32'h7F);
      repeat (2 * FL) @(posedge clk);
      cmp({25'h0, rx_ra}, 32'h0);
      print_verdict();
   end
endmodule // tb_t2x_framer_ctl
